// file: src/csd_defs.vh
// Constants for the card configuration record image and its APB register map
`ifndef CSD_DEFS_VH
`define CSD_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// APB map, byte addresses
`define CSD_ADDR_W        8
`define CSD_OFF_WORD0     8'h00
`define CSD_OFF_WORD1     8'h04
`define CSD_OFF_WORD2     8'h08
`define CSD_OFF_WORD3     8'h0c
`define CSD_OFF_CONFIG    8'h10
`define CSD_OFF_STATUS    8'h14

////////////////////////////////////////////////////////////////////////////////
// Writable bits inside word 0
`define CSD_FFG_BIT       15
`define CSD_COPY_BIT      14
`define CSD_PERM_BIT      13
`define CSD_TMP_BIT       12
`define CSD_FF_HI         11
`define CSD_FF_LO         10

// Config register fields
`define CSD_CFG_BL_HI     3
`define CSD_CFG_BL_LO     0
`define CSD_CFG_HS_BIT    4
`define CSD_CFG_CS_HI     19
`define CSD_CFG_CS_LO     8
`define CSD_CFG_CM_HI     22
`define CSD_CFG_CM_LO     20

// Status register fields
`define CSD_ST_BUSY_BIT   0
`define CSD_ST_CRC_HI     7
`define CSD_ST_CRC_LO     1

////////////////////////////////////////////////////////////////////////////////
// Fixed field codes
`define CSD_LAYOUT_V10    2'h0
`define CSD_RSV6          6'h00
`define CSD_ASYNC_ACCESS  8'h26
`define CSD_CLOCKED_ACC   8'h00
`define CSD_RATE_DEFAULT  8'h32
`define CSD_RATE_HIGH     8'h5a
`define CSD_CMD_CLASSES   12'h5f5
`define CSD_RD_PARTIAL    1'h1
`define CSD_WR_MISALIGN   1'h0
`define CSD_RD_MISALIGN   1'h0
`define CSD_DSR_IMP       1'h0
`define CSD_RSV2          2'h0
`define CSD_R_CURR_MIN    3'h7
`define CSD_R_CURR_MAX    3'h6
`define CSD_W_CURR_MIN    3'h7
`define CSD_W_CURR_MAX    3'h6
`define CSD_SINGLE_BLOCK_ERASE_ENABLE  1'h1
`define CSD_SECTOR_SIZE   7'h1f
`define CSD_PROT_GRP_SIZE 7'h7f
`define CSD_PROT_GRP_EN   1'h1
`define CSD_R2W_FACTOR    3'h4
`define CSD_WR_PARTIAL    1'h0
`define CSD_RSV5          5'h00
`define CSD_END_BIT       1'h1

// Block length limits, log2 of bytes
`define CSD_BL_MIN        4'h9
`define CSD_BL_MAX        4'hb

// Reset values of writable state
`define CSD_RST_BL        4'h9
`define CSD_RST_CSIZE     12'hf22
`define CSD_RST_CMULT     3'h7
`define CSD_RST_FFG       1'h0
`define CSD_RST_COPY      1'h1
`define CSD_RST_PERM      1'h0
`define CSD_RST_TMP       1'h0
`define CSD_RST_FF        2'h0

// CRC7 engine
`define CSD_CRC_BITS      7'h78
`define CSD_CRC_POLY      7'h09

`endif

// file: src/csd_crc7.v
// Serial CRC7 engine over the upper 120 bits of the record
`timescale 1ns/1ps
`default_nettype none
`include "csd_defs.vh"

module csd_crc7 (
	input  wire         pclk,    // Clock
	input  wire         presetn, // Async reset, low
	input  wire         start,   // Snapshot data and restart
	input  wire [119:0] data,    // Record bits 127:8
	output reg          busy,    // Computation running
	output reg  [6:0]   crc      // Last finished checksum
);

	reg  [119:0] shadow;
	reg  [6:0]   acc;
	reg  [6:0]   left;
	wire         fb = shadow[119] ^ acc[6];

	// One bit per cycle, msb first; restart drops any run in flight
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shadow <= 120'h0;
			acc    <= 7'h00;
			left   <= 7'h00;
			busy   <= 1'b0;
			crc    <= 7'h00;
		end else if (start) begin
			shadow <= data;
			acc    <= 7'h00;
			left   <= `CSD_CRC_BITS;
			busy   <= 1'b1;
		end else if (busy) begin
			shadow <= {shadow[118:0], 1'b0};
			acc    <= {acc[5:0], 1'b0} ^ (fb ? `CSD_CRC_POLY : 7'h00);
			left   <= left - 7'h01;
			if (left == 7'h01) begin
				busy <= 1'b0;
				crc  <= {acc[5:0], 1'b0} ^ (fb ? `CSD_CRC_POLY : 7'h00);
			end
		end
	end

endmodule
`default_nettype wire

// file: src/csd_otp_field.v
// One-time programmable field: first write sticks, later writes ignored
`timescale 1ns/1ps
`default_nettype none

module csd_otp_field #(
	parameter W = 1,          // Field width
	parameter [W-1:0] INIT = 0 // Value before programming
) (
	input  wire         pclk,    // Clock
	input  wire         presetn, // Async reset, low
	input  wire         wr,      // Write strobe
	input  wire [W-1:0] wdata,   // Value to program
	output reg  [W-1:0] value,   // Current field value
	output reg          burnt    // Field already programmed
);

	// Reset stands in for a fresh part; real fuses would survive it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= INIT;
			burnt <= 1'b0;
		end else if (wr && !burnt) begin
			value <= wdata;
			burnt <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// file: src/csd_card_specific_data.v
// APB-readable image of the card configuration record with CRC and writable bits
`timescale 1ns/1ps
`default_nettype none
`include "csd_defs.vh"

module csd_card_specific_data (
	input  wire        pclk,    // APB clock, 250 MHz
	input  wire        presetn, // Async reset, low
	input  wire        psel,    // Slave select
	input  wire        penable, // Access phase
	input  wire        pwrite,  // Write, else read
	input  wire [7:0]  paddr,   // Byte address
	input  wire [31:0] pwdata,  // Write data
	output wire        pready,  // Always ready in access
	output reg  [31:0] prdata,  // Read data, registered
	output reg         pslverr  // Unmapped address
);

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire setup    = psel & ~penable;
	wire wr_acc   = psel & penable & pwrite;
	wire hit_w0   = (paddr == `CSD_OFF_WORD0);
	wire hit_w1   = (paddr == `CSD_OFF_WORD1);
	wire hit_w2   = (paddr == `CSD_OFF_WORD2);
	wire hit_w3   = (paddr == `CSD_OFF_WORD3);
	wire hit_cfg  = (paddr == `CSD_OFF_CONFIG);
	wire hit_st   = (paddr == `CSD_OFF_STATUS);
	wire mapped   = hit_w0 | hit_w1 | hit_w2 | hit_w3 | hit_cfg | hit_st;
	wire wr_w0    = wr_acc & hit_w0;
	wire wr_cfg   = wr_acc & hit_cfg;

	// Zero wait states keep the host's access-time math simple
	assign pready = psel & penable;

	////////////////////////////////////////////////////////////////////////
	// Configuration state
	reg  [3:0]  blk_len;
	reg         high_speed;
	reg  [11:0] dev_size;
	reg  [2:0]  size_mult;
	reg         tmp_protect;
	wire [3:0]  new_bl  = pwdata[`CSD_CFG_BL_HI:`CSD_CFG_BL_LO];
	wire        bl_ok   = (new_bl >= `CSD_BL_MIN) && (new_bl <= `CSD_BL_MAX);

	// Out-of-range block lengths keep the old value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blk_len    <= `CSD_RST_BL;
			high_speed <= 1'b0;
			dev_size   <= `CSD_RST_CSIZE;
			size_mult  <= `CSD_RST_CMULT;
		end else if (wr_cfg) begin
			if (bl_ok)
				blk_len <= new_bl;
			high_speed <= pwdata[`CSD_CFG_HS_BIT];
			dev_size   <= pwdata[`CSD_CFG_CS_HI:`CSD_CFG_CS_LO];
			size_mult  <= pwdata[`CSD_CFG_CM_HI:`CSD_CFG_CM_LO];
		end
	end

	// Temporary protection may be set and cleared freely
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tmp_protect <= `CSD_RST_TMP;
		else if (wr_w0)
			tmp_protect <= pwdata[`CSD_TMP_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// One-time programmable flags
	wire       fmt_grp;
	wire       copy_flag;
	wire       perm_protect;
	wire [1:0] file_fmt;

	csd_otp_field #(.W(1), .INIT(`CSD_RST_FFG)) u_ffg (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr_w0),
		.wdata   (pwdata[`CSD_FFG_BIT]),
		.value   (fmt_grp),
		.burnt   ()
	);

	csd_otp_field #(.W(1), .INIT(`CSD_RST_COPY)) u_copy (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr_w0),
		.wdata   (pwdata[`CSD_COPY_BIT]),
		.value   (copy_flag),
		.burnt   ()
	);

	csd_otp_field #(.W(1), .INIT(`CSD_RST_PERM)) u_perm (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr_w0),
		.wdata   (pwdata[`CSD_PERM_BIT]),
		.value   (perm_protect),
		.burnt   ()
	);

	csd_otp_field #(.W(2), .INIT(`CSD_RST_FF)) u_ff (
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (wr_w0),
		.wdata   (pwdata[`CSD_FF_HI:`CSD_FF_LO]),
		.value   (file_fmt),
		.burnt   ()
	);

	////////////////////////////////////////////////////////////////////////
	// Record assembly, msb first
	wire [7:0] rate_code = high_speed ? `CSD_RATE_HIGH : `CSD_RATE_DEFAULT;
	wire [6:0] crc;

	// Upper 120 bits feed the checksum
	wire [119:0] body = {
		`CSD_LAYOUT_V10,
		`CSD_RSV6,
		`CSD_ASYNC_ACCESS,
		`CSD_CLOCKED_ACC,
		rate_code,
		`CSD_CMD_CLASSES,
		blk_len,
		`CSD_RD_PARTIAL,
		`CSD_WR_MISALIGN,
		`CSD_RD_MISALIGN,
		`CSD_DSR_IMP,
		`CSD_RSV2,
		dev_size,
		`CSD_R_CURR_MIN,
		`CSD_R_CURR_MAX,
		`CSD_W_CURR_MIN,
		`CSD_W_CURR_MAX,
		size_mult,
		`CSD_SINGLE_BLOCK_ERASE_ENABLE,
		`CSD_SECTOR_SIZE,
		`CSD_PROT_GRP_SIZE,
		`CSD_PROT_GRP_EN,
		`CSD_RSV2,
		`CSD_R2W_FACTOR,
		blk_len,
		`CSD_WR_PARTIAL,
		`CSD_RSV5,
		fmt_grp,
		copy_flag,
		perm_protect,
		tmp_protect,
		file_fmt,
		`CSD_RSV2
	};

	wire [127:0] record = {body, crc, `CSD_END_BIT};

	////////////////////////////////////////////////////////////////////////
	// Checksum upkeep
	reg  kick;
	wire crc_busy;

	// Recompute after reset and after any write that can alter the body
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			kick <= 1'b1;
		else
			kick <= wr_w0 | wr_cfg;
	end

	csd_crc7 u_crc (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (kick),
		.data    (body),
		.busy    (crc_busy),
		.crc     (crc)
	);

	////////////////////////////////////////////////////////////////////////
	// Read path
	reg [31:0] next_rdata;

	// Status shows the engine; stale CRC is visible while busy is high
	always @* begin
		next_rdata = 32'h0000_0000;
		if (hit_w0)
			next_rdata = record[31:0];
		else if (hit_w1)
			next_rdata = record[63:32];
		else if (hit_w2)
			next_rdata = record[95:64];
		else if (hit_w3)
			next_rdata = record[127:96];
		else if (hit_cfg) begin
			next_rdata[`CSD_CFG_BL_HI:`CSD_CFG_BL_LO] = blk_len;
			next_rdata[`CSD_CFG_HS_BIT]               = high_speed;
			next_rdata[`CSD_CFG_CS_HI:`CSD_CFG_CS_LO] = dev_size;
			next_rdata[`CSD_CFG_CM_HI:`CSD_CFG_CM_LO] = size_mult;
		end else if (hit_st) begin
			next_rdata[`CSD_ST_BUSY_BIT]              = crc_busy;
			next_rdata[`CSD_ST_CRC_HI:`CSD_ST_CRC_LO] = crc;
		end
	end

	// Captured in setup so the access phase sees flopped data
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= ~mapped;
		end
	end

endmodule
`default_nettype wire

// file: dv/csd_card_specific_data_sva.sv
// Checker for the configuration record register bank
`timescale 1ns/1ps
`default_nettype none

module csd_card_specific_data_sva (
	input wire logic        pclk,    // Clock
	input wire logic        presetn, // Async reset, low
	input wire logic        psel,    // Select
	input wire logic        penable, // Access phase
	input wire logic        pwrite,  // Write, else read
	input wire logic [7:0]  paddr,   // Byte address
	input wire logic [31:0] pwdata,  // Write data
	input wire logic        pready,  // Ready
	input wire logic [31:0] prdata,  // Read data
	input wire logic        pslverr  // Error
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Read setup to one address; data stands from the next edge
	sequence rd_at(logic [7:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	a_ready_access: assert property (pready == (psel && penable))
		else $error("ready not tied to access phase");
	a_word3_fixed: assert property (rd_at(8'h0c) |=> prdata[31:16] == 16'h0026)
		else $error("top word head wrong");
	a_rate_code: assert property (rd_at(8'h0c) |=>
		prdata[2:0] <= 3'h3 && prdata[6:3] != 4'h0 && !prdata[7])
		else $error("rate byte wrong");
	a_class_mask: assert property (rd_at(8'h08) |=>
		prdata[31:20] == 12'h5f5 && prdata[11:10] == 2'h0)
		else $error("class mask wrong");
	a_block_range: assert property (rd_at(8'h08) |=>
		prdata[19:16] >= 4'h9 && prdata[19:16] <= 4'hb)
		else $error("read block length out of range");
	a_erase_protect: assert property (rd_at(8'h04) |=>
		prdata[14:0] == 15'h4fff)
		else $error("erase or protect fields wrong");
	a_word0_fixed: assert property (rd_at(8'h00) |=>
		prdata[31:29] == 3'h4 && prdata[21:16] == 6'h0 && prdata[9:8] == 2'h0 && prdata[0])
		else $error("low word fixed bits wrong");
	a_unmapped_err: assert property (psel && !penable && paddr > 8'h14 && paddr[1:0] == 2'h0
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped access not flagged");

	// Main scenarios
	c_read_low: cover property (rd_at(8'h00));
	c_cfg_write: cover property (psel && penable && pwrite && paddr == 8'h10);
	c_error: cover property (pslverr && pready);
	c_flag_write: cover property (psel && penable && pwrite && paddr == 8'h00);
endmodule

bind csd_card_specific_data csd_card_specific_data_sva u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr));
`default_nettype wire

// file: dv/csd_host_model.sv
// Host side decoder of the configuration record
`timescale 1ns/1ps
`default_nettype none

module csd_host_model #(
	parameter int CLK_NS = 4 // Card clock period in ns
) (
	input  wire logic [31:0] word3,       // Record bits 127:96
	input  wire logic [31:0] word2,       // Record bits 95:64
	output logic      [31:0] access_ns,   // Total read access time
	output logic      [15:0] block_bytes, // Max read block
	output logic             layout_ok    // Usable layout version
);
	// Mantissa in tenths; code 0 reserved
	localparam int TAB [16] = '{0, 10, 12, 13, 15, 20, 25, 30, 35, 40, 45, 50, 55, 60, 70, 80};

	// Asynchronous part plus clocked part at our own clock rate, taken as
	// typical delay from command end bit to first data bit
	assign access_ns = 32'(TAB[word3[22:19]] * (10 ** word3[18:16]) / 10
		+ word3[15:8] * 100 * CLK_NS);
	assign block_bytes = 16'h1 << word2[19:16];
	// Reserved versions refused
	assign layout_ok = word3[31:30] == 2'h0;
endmodule
`default_nettype wire

// file: dv/tb.sv
// Testbench for the configuration record register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        pclk, presetn, psel, penable, pwrite, e, lay_ok;
	logic [7:0]  paddr;
	logic [31:0] pwdata, w3, w2, d, acc_ns;
	logic [15:0] blk;
	logic [6:0]  crc_exp;
	wire         pready, pslverr;
	wire  [31:0] prdata;
	int          error_cnt = 0;
	int          checks = 0;
	int          cyc = 0;

	csd_card_specific_data u_csd_card_specific_data (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr));
	csd_host_model u_csd_host_model (.word3(w3), .word2(w2), .access_ns(acc_ns),
		.block_bytes(blk), .layout_ok(lay_ok));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hang guard; whole run is a few hundred cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			end_of_test;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; waits for pready however long it takes
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reference checksum, straight from the generator x^7 + x^3 + 1
	function automatic logic [6:0] crc7_of(input logic [119:0] m);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 119; i >= 0; i--)
			c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? 7'h09 : 7'h00);
		return c;
	endfunction

	task end_of_test;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		w3 = 32'h0;
		w2 = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Image after reset
		apb(1'b0, 8'h0c, 32'h0, w3, e);
		chk(w3, 32'h0026_0032);
		apb(1'b0, 8'h08, 32'h0, w2, e);
		chk(w2, 32'h5f59_83c8);
		apb(1'b0, 8'h04, 32'h0, d, e);
		chk(d, 32'hbefb_cfff);
		apb(1'b0, 8'h00, 32'h0, d, e);
		chk(d & 32'hffff_ff01, 32'h9240_4001);
		#1;
		chk(acc_ns, 32'd1500000);
		chk({16'h0, blk}, 32'd512);
		chk({31'h0, lay_ok}, 32'h1);
		// Let the power-up checksum run finish so the next busy is the write's
		repeat (130) @(posedge pclk);
		crc_exp = crc7_of({32'h0026_0032, 32'h5f59_83c8, 32'hbefb_cfff, 24'h92_4040});
		apb(1'b0, 8'h14, 32'h0, d, e);
		chk({31'h0, d[0]}, 32'h0);
		chk({25'h0, d[7:1]}, {25'h0, crc_exp});
		$display("test reset_image done");
		// Largest block and fast rate; the write restarts the checksum
		apb(1'b1, 8'h10, 32'h007f_221b, d, e);
		apb(1'b0, 8'h14, 32'h0, d, e);
		chk({31'h0, d[0]}, 32'h1);
		apb(1'b0, 8'h0c, 32'h0, w3, e);
		chk({24'h0, w3[7:0]}, 32'h5a);
		apb(1'b0, 8'h08, 32'h0, w2, e);
		chk({28'h0, w2[19:16]}, 32'hb);
		apb(1'b0, 8'h00, 32'h0, d, e);
		chk({28'h0, d[25:22]}, 32'hb);
		#1;
		chk({16'h0, blk}, 32'd2048);
		// Checksum engine needs 120 cycles
		repeat (130) @(posedge pclk);
		crc_exp = crc7_of({32'h0026_005a, 32'h5f5b_83c8, 32'hbefb_cfff, 24'h92_c040});
		apb(1'b0, 8'h14, 32'h0, d, e);
		chk({31'h0, d[0]}, 32'h0);
		chk({25'h0, d[7:1]}, {25'h0, crc_exp});
		apb(1'b0, 8'h00, 32'h0, d, e);
		chk({24'h0, d[7:0]}, {24'h0, crc_exp, 1'b1});
		$display("test wide_block done");
		// Out-of-range length is kept, rate back to default
		apb(1'b1, 8'h10, 32'h007f_220c, d, e);
		apb(1'b0, 8'h08, 32'h0, d, e);
		chk({28'h0, d[19:16]}, 32'hb);
		apb(1'b0, 8'h00, 32'h0, d, e);
		chk({28'h0, d[25:22]}, 32'hb);
		apb(1'b0, 8'h0c, 32'h0, d, e);
		chk({24'h0, d[7:0]}, 32'h32);
		apb(1'b0, 8'h10, 32'h0, d, e);
		chk(d, 32'h007f_220b);
		$display("test bad_length done");
		// Word 0 flags: first write sticks, temporary bit follows every write
		apb(1'b1, 8'h00, 32'h0000_fc00, d, e);
		apb(1'b0, 8'h00, 32'h0, d, e);
		chk({26'h0, d[15:10]}, 32'h3f);
		apb(1'b1, 8'h00, 32'h0, d, e);
		apb(1'b0, 8'h00, 32'h0, d, e);
		chk({26'h0, d[15:10]}, 32'h3b);
		chk({30'h0, d[9:8]}, 32'h0);
		// Reset in mid-run brings back the fresh image
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0, d, e);
		chk(d & 32'hffff_ff01, 32'h9240_4001);
		apb(1'b0, 8'h10, 32'h0, d, e);
		chk(d, 32'h007f_2209);
		$display("test flags done");
		// Read-only word and an unmapped place
		apb(1'b1, 8'h0c, 32'hffff_ffff, d, e);
		apb(1'b0, 8'h0c, 32'h0, d, e);
		chk(d, 32'h0026_0032);
		apb(1'b0, 8'h18, 32'h0, d, e);
		chk({31'h0, e}, 32'h1);
		chk(d, 32'h0);
		$display("test read_only done");
		end_of_test;
	end
endmodule
`default_nettype wire
